// File: rtl/fsp_wl_pkg.sv
// shared constants, types and helpers for the set-point and leveling link
package fsp_wl_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 10000;
  localparam int FC_SHORT_NS   = 200;
  localparam int FC_MIDDLE_NS  = 200;
  localparam int FC_LONG_NS    = 250;
  localparam int FC_SHORT_CYC  = (FC_SHORT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FC_MIDDLE_CYC = (FC_MIDDLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FC_LONG_CYC   = (FC_LONG_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CK_HALF       = 6;            // link clock half period in CLK cycles
  localparam int CK_PER        = 2 * CK_HALF;
  localparam int CKV_PS        = 7500;
  localparam int CKV_NCK       = 4;
  localparam int CKV_T_CYC     = (CKV_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CKV_CYC       = (CKV_NCK * CK_PER > CKV_T_CYC) ? CKV_NCK * CK_PER : CKV_T_CYC;
  localparam int WL_DQS_EN_NCK = 20;
  localparam int WL_FIRST_NCK  = 40;
  localparam int MIN_PULSES    = 2;
  // ---------------------------------------------------------------
  // mode registers and fields
  // ---------------------------------------------------------------
  localparam logic [5:0] MR_LAT_LVL = 6'h02;   // latency_leveling_register
  localparam logic [5:0] MR_CMD_REF = 6'h0C;   // command_reference_register
  localparam logic [5:0] MR_SP_CTL  = 6'h0D;   // setpoint_control_register
  localparam int WLEN_BIT  = 7;
  localparam int OPSEL_BIT = 7;
  localparam int WSEL_BIT  = 6;
  localparam int VREF_CURRENT_MODE_BIT  = 3;
  localparam int RANGE_BIT = 6;
  localparam logic [6:0] CMD_REF_RST = 7'h4D;  // unterminated low-speed level
  localparam logic [7:0] SP_CTL_RST  = 8'h00;
  localparam logic [7:0] LAT_LVL_RST = 8'h00;
  // ---------------------------------------------------------------
  // controller register port
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_MRW    = 8'h00;
  localparam logic [7:0] REG_FSP    = 8'h04;
  localparam logic [7:0] REG_PULSE  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam int MRW_MA_LSB = 8;
  localparam int PUL_DLY_LSB = 8;
  localparam int ST_BUSY = 0;
  localparam int ST_SET  = 1;
  localparam int ST_WL   = 2;
  localparam int ST_RDY  = 3;
  localparam int ST_FB   = 4;
  localparam int ST_CLS  = 6;
  localparam int ST_REF  = 8;

  typedef enum logic [1:0] {SW_SHORT = 2'h0, SW_MIDDLE = 2'h1, SW_LONG = 2'h2} sw_class_t;
  typedef enum logic [2:0] {
    C_IDLE = 3'h0, C_SEND = 3'h1, C_HOLD = 3'h3, C_WAIT = 3'h2, C_PRE = 3'h6, C_PULSE = 3'h4
  } ctl_state_t;

  // switch time class from the two command reference sets
  function automatic sw_class_t switch_class(input logic [6:0] a, input logic [6:0] b);
    logic [5:0] d;
    d = (a[5:0] > b[5:0]) ? a[5:0] - b[5:0] : b[5:0] - a[5:0];
    if (a[RANGE_BIT] != b[RANGE_BIT])
      return SW_LONG;
    return (d <= 6'h01) ? SW_SHORT : SW_MIDDLE;
  endfunction

  function automatic logic [7:0] fc_cycles(input sw_class_t c);
    case (c)
      SW_LONG:   return 8'(FC_LONG_CYC);
      SW_MIDDLE: return 8'(FC_MIDDLE_CYC);
      default:   return 8'(FC_SHORT_CYC);
    endcase
  endfunction
endpackage

// File: rtl/fsp_wl_if.sv
// link between the memory controller end and the dram end
`timescale 1ns/1ps
interface fsp_wl_if;
  logic        ck;      // link clock, made by the controller
  logic        mrw;     // mode register write, taken at ck rise
  logic [5:0]  ma;      // mode register address
  logic [7:0]  op;      // mode register operand
  logic [1:0]  dqs_t;   // true strobe per byte
  logic [1:0]  dqs_c;   // complement strobe per byte
  logic        dqs_oe;  // controller drives strobes
  logic [15:0] dq_o;    // dram data pins
  logic        dq_oe;   // dram drives data pins
  modport ctl  (output ck, mrw, ma, op, dqs_t, dqs_c, dqs_oe, input dq_o, dq_oe);
  modport dram (input ck, mrw, ma, op, dqs_t, dqs_c, dqs_oe, output dq_o, dq_oe);
endinterface

// File: rtl/fsp_wl_dram.sv
// dram end: duplicated set-point registers and write-leveling feedback
`timescale 1ns/1ps
module fsp_wl_dram
(
  // clock and reset
  input  wire logic                  CLK,
  input  wire logic                  NRST,
  // link
  fsp_wl_if.dram                     LINK,
  // status
  output logic                       ACTIVE_SET,
  output logic                       SWITCHING,
  output fsp_wl_pkg::sw_class_t      SWITCH_CLASS,
  output logic                       VREF_FAST,
  output logic                       WL_ACTIVE
);
  import fsp_wl_pkg::*;

  typedef struct packed {
    logic [1:0]      ck_s;
    logic            ck_d;
    logic [1:0]      mrw_s;
    logic [1:0][5:0] ma_s;
    logic [1:0][7:0] op_s;
    logic [1:0][1:0] dqs_s;
    logic [1:0]      dqs_d;
    logic [7:0]      lat_lvl;
    logic [7:0]      sp_ctl;
    logic [1:0][6:0] cmd_ref;
    logic [7:0]      timer;
    logic            busy;
    sw_class_t       cls;
    logic [1:0]      lvl;
    logic            dq_oe;
  } dram_state_t;

  dram_state_t s_reg;
  dram_state_t s_next;
  logic        ck_rise;
  logic        take;

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    // every link input passes two flops before use
    s_next.ck_s   = {s_reg.ck_s[0], LINK.ck};
    s_next.ck_d   = s_reg.ck_s[1];
    s_next.mrw_s  = {s_reg.mrw_s[0], LINK.mrw};
    s_next.ma_s   = {s_reg.ma_s[0], LINK.ma};
    s_next.op_s   = {s_reg.op_s[0], LINK.op};
    s_next.dqs_s  = {s_reg.dqs_s[0], LINK.dqs_t & {2{LINK.dqs_oe}}};
    s_next.dqs_d  = s_reg.dqs_s[1];
    ck_rise = s_reg.ck_s[1] & ~s_reg.ck_d;
    take    = ck_rise & s_reg.mrw_s[1];
    // switch timer
    if (s_reg.timer != 8'h00)
      s_next.timer = s_reg.timer - 8'h01;
    if (s_reg.timer == 8'h01)
      s_next.busy = 1'b0;
    if (take)
    begin
      unique case (s_reg.ma_s[1])
        MR_SP_CTL:
        begin
          s_next.sp_ctl = s_reg.op_s[1];
          if (s_reg.op_s[1][OPSEL_BIT] != s_reg.sp_ctl[OPSEL_BIT])
          begin
            s_next.cls   = switch_class(s_reg.cmd_ref[0], s_reg.cmd_ref[1]);
            s_next.timer = fc_cycles(s_next.cls);
            s_next.busy  = 1'b1;
          end
        end
        // writes land in the set chosen by the write-select bit
        MR_CMD_REF: s_next.cmd_ref[s_reg.sp_ctl[WSEL_BIT]] = s_reg.op_s[1][6:0];
        MR_LAT_LVL:
        begin
          s_next.lat_lvl = s_reg.op_s[1];
          s_next.dq_oe   = s_reg.op_s[1][WLEN_BIT];
          if (s_reg.op_s[1][WLEN_BIT] && !s_reg.lat_lvl[WLEN_BIT])
            s_next.lvl = 2'b00;  // pins undefined on entry, zero chosen
        end
        default: ;
      endcase
    end
    // per-byte capture of the clock level on each true strobe rise
    for (int b = 0; b < 2; b++)
    begin
      if (s_reg.lat_lvl[WLEN_BIT] && s_reg.dqs_s[1][b] && !s_reg.dqs_d[b])
        s_next.lvl[b] = s_reg.ck_s[1];
    end
  end

  // -------------------------------------------------------------
  // state register
  // -------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      s_reg         <= '0;
      s_reg.sp_ctl  <= SP_CTL_RST;
      s_reg.lat_lvl <= LAT_LVL_RST;
      s_reg.cmd_ref <= {CMD_REF_RST, CMD_REF_RST};
      s_reg.cls     <= SW_SHORT;
    end
    else
      s_reg <= s_next;
  end

  // outputs straight from the state register
  assign LINK.dq_o    = {{8{s_reg.lvl[1]}}, {8{s_reg.lvl[0]}}};
  assign LINK.dq_oe   = s_reg.dq_oe;
  assign ACTIVE_SET   = s_reg.sp_ctl[OPSEL_BIT];
  assign SWITCHING    = s_reg.busy;
  assign SWITCH_CLASS = s_reg.cls;
  assign VREF_FAST    = s_reg.sp_ctl[VREF_CURRENT_MODE_BIT];
  assign WL_ACTIVE    = s_reg.lat_lvl[WLEN_BIT];
endmodule

// File: rtl/fsp_wl_ctl.sv
// controller end: set-point switch sequencing and write-leveling strobes
//
// How it works
// - switch write also sets fast vref current
// - vref current back to normal after wait
// - wait 200 or 250 ns by class
// - clock stays valid after switch entry
// - valid clock before first later command
// - one step short, more steps middle
// - range change always long switch time
// - dram starts on set zero
// - both sets reset to low-speed values
// - train alternate set before switching to it
// - trained sets switch with one write
// - third set rewritten into inactive set first
// - strobe rise samples clock, fed back per byte
// - each strobe pair leveled on its own; here both pairs are pulsed together with one shared delay
// - leveling bit enters and exits the mode
// - only deselect or exit during leveling
// - strobes parked after strobe-enable delay
// - wait first-strobe delay before pulsing
// - at least two pulses per burst
// - newest strobe edge overwrites sampled level
// - software sweeps delay, then exits leveling
// - level before write training
// - feedback within leveling output delay
// - select bit picks set zero or one
`timescale 1ns/1ps
module fsp_wl_ctl
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        NRST,
  // register port
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic [31:0]      RDATA,
  output logic             BUSY,
  // link
  fsp_wl_if.ctl            LINK
);
  import fsp_wl_pkg::*;

  typedef struct packed {
    ctl_state_t       st;
    ctl_state_t       ret;
    logic [3:0]       div;
    logic             ck;
    logic             mrw;
    logic [5:0]       ma;
    logic [7:0]       op;
    logic [5:0]       pend_ma;
    logic [7:0]       pend_op;
    logic [7:0]       cnt;
    logic [7:0]       fc_cyc;
    sw_class_t        cls;
    logic [7:0]       sp_ctl;
    logic [1:0][6:0]  cmd_ref;
    logic             wl;
    logic [5:0]       wl_cnt;
    logic             dqs_t;
    logic             dqs_c;
    logic             dqs_oe;
    logic [3:0]       pulses;
    logic [3:0]       dly;
    logic             armed;
    logic [1:0][15:0] dq_s;
    logic             refused;
    logic [31:0]      rdata;
    logic             busy;
  } ctl_reg_t;

  ctl_reg_t   c_reg;
  ctl_reg_t   c_next;
  logic       nck_tick;
  logic       fall_tick;
  logic [3:0] ph;
  logic       live;
  logic       ok;
  logic [7:0] sw_op;

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb
  begin
    c_next = c_reg;
    ok     = 1'b0;
    sw_op  = c_reg.sp_ctl;
    // link clock divider, runs always so the clock is never stopped
    c_next.div = (c_reg.div == 4'(CK_PER - 1)) ? 4'h0 : c_reg.div + 4'h1;
    c_next.ck  = (c_next.div < 4'(CK_HALF));
    nck_tick   = (c_reg.div == 4'(CK_PER - 1));
    fall_tick  = (c_reg.div == 4'(CK_HALF - 1));
    c_next.dq_s = {c_reg.dq_s[0], LINK.dq_o};
    // leveling delay count in link clocks, saturating; it starts only once the entry
    // command is out, so a rise before the command never shortens the delays
    if (c_reg.wl && c_reg.st != C_SEND && nck_tick && c_reg.wl_cnt != 6'(WL_FIRST_NCK))
      c_next.wl_cnt = c_reg.wl_cnt + 6'h01;
    c_next.dqs_oe = c_reg.wl && (c_reg.wl_cnt >= 6'(WL_DQS_EN_NCK));
    if (c_reg.cnt != 8'h00)
      c_next.cnt = c_reg.cnt - 8'h01;
    // strobe phase relative to the link clock rise
    ph   = (c_reg.div >= c_reg.dly) ? c_reg.div - c_reg.dly
                                    : 4'(c_reg.div + 4'(CK_PER) - c_reg.dly);
    live = c_reg.armed | (ph == 4'h0 && c_reg.pulses != 4'h0);
    c_next.dqs_t = (c_reg.st == C_PULSE) && live && (ph < 4'(CK_HALF));
    c_next.dqs_c = ~c_next.dqs_t;
    // sequencer
    unique case (c_reg.st)
      C_IDLE: ;
      C_SEND:
      begin
        // command held from one ck fall to the next, centred on a rise
        if (fall_tick)
        begin
          c_next.mrw = !c_reg.mrw;
          c_next.ma  = c_reg.pend_ma;
          c_next.op  = c_reg.pend_op;
          if (c_reg.mrw)
          begin
            c_next.st  = c_reg.ret;
            c_next.cnt = 8'(CKV_CYC);
          end
        end
      end
      C_HOLD:
        if (c_reg.cnt == 8'h00)
        begin
          c_next.st  = C_WAIT;
          c_next.cnt = c_reg.fc_cyc;
        end
      C_WAIT:
        if (c_reg.cnt == 8'h00)
        begin
          c_next.st  = C_PRE;
          c_next.cnt = 8'(CKV_CYC);
        end
      C_PRE:
        if (c_reg.cnt == 8'h00)
        begin
          c_next.sp_ctl[VREF_CURRENT_MODE_BIT] = 1'b0;
          c_next.pend_op = c_next.sp_ctl;
          c_next.ret     = C_IDLE;
          c_next.st      = C_SEND;
        end
      C_PULSE:
      begin
        if (ph == 4'h0 && c_reg.pulses != 4'h0)
          c_next.armed = 1'b1;
        if (c_reg.armed && ph == 4'(CK_PER - 1))
        begin
          c_next.armed  = 1'b0;
          c_next.pulses = c_reg.pulses - 4'h1;
          if (c_reg.pulses == 4'h1)
            c_next.st = C_IDLE;
        end
      end
      default: c_next.st = C_IDLE;
    endcase
    // register writes, taken only while idle
    if (WR)
    begin
      unique case (ADDR)
        REG_MRW:
        begin
          // no set-point change by a raw write; leveling lets only its exit through
          ok = (c_reg.st == C_IDLE)
               && !(WDATA[MRW_MA_LSB +: 6] == MR_SP_CTL
                    && WDATA[OPSEL_BIT] != c_reg.sp_ctl[OPSEL_BIT])
               && (!c_reg.wl || (WDATA[MRW_MA_LSB +: 6] == MR_LAT_LVL
                                 && !WDATA[WLEN_BIT]));
          if (ok)
          begin
            c_next.pend_ma = WDATA[MRW_MA_LSB +: 6];
            c_next.pend_op = WDATA[7:0];
            c_next.ret     = C_IDLE;
            c_next.st      = C_SEND;
            if (WDATA[MRW_MA_LSB +: 6] == MR_SP_CTL)
              c_next.sp_ctl = WDATA[7:0];
            if (WDATA[MRW_MA_LSB +: 6] == MR_CMD_REF)
              c_next.cmd_ref[c_reg.sp_ctl[WSEL_BIT]] = WDATA[6:0];
            if (WDATA[MRW_MA_LSB +: 6] == MR_LAT_LVL)
            begin
              c_next.wl     = WDATA[WLEN_BIT];
              c_next.wl_cnt = 6'h00;
            end
          end
        end
        REG_FSP:
        begin
          ok = (c_reg.st == C_IDLE) && !c_reg.wl;
          if (ok)
          begin
            sw_op[OPSEL_BIT] = WDATA[0];
            sw_op[VREF_CURRENT_MODE_BIT]  = 1'b1;
            c_next.sp_ctl  = sw_op;
            c_next.pend_ma = MR_SP_CTL;
            c_next.pend_op = sw_op;
            c_next.cls     = switch_class(c_reg.cmd_ref[0], c_reg.cmd_ref[1]);
            c_next.fc_cyc  = fc_cycles(c_next.cls);
            c_next.ret     = C_HOLD;
            c_next.st      = C_SEND;
          end
        end
        REG_PULSE:
        begin
          ok = (c_reg.st == C_IDLE) && c_reg.wl
               && (c_reg.wl_cnt == 6'(WL_FIRST_NCK));
          if (ok)
          begin
            c_next.pulses = (WDATA[3:0] < 4'(MIN_PULSES)) ? 4'(MIN_PULSES)
                                                          : WDATA[3:0];
            c_next.dly    = (WDATA[PUL_DLY_LSB +: 4] > 4'(CK_PER - 1))
                            ? 4'(CK_PER - 1) : WDATA[PUL_DLY_LSB +: 4];
            c_next.armed  = 1'b0;
            c_next.st     = C_PULSE;
          end
        end
        default: ok = 1'b1;  // unmapped writes are dropped silently
      endcase
    end
    // read data stands one cycle; a refusal in the read cycle survives
    c_next.rdata = 32'h0000_0000;
    if (RD && ADDR == REG_STATUS)
    begin
      c_next.rdata[ST_BUSY]     = (c_reg.st != C_IDLE);
      c_next.rdata[ST_SET]      = c_reg.sp_ctl[OPSEL_BIT];
      c_next.rdata[ST_WL]       = c_reg.wl;
      c_next.rdata[ST_RDY]      = c_reg.wl && (c_reg.wl_cnt == 6'(WL_FIRST_NCK));
      c_next.rdata[ST_FB +: 2]  = {c_reg.dq_s[1][8], c_reg.dq_s[1][0]};
      c_next.rdata[ST_CLS +: 2] = c_reg.cls;
      c_next.rdata[ST_REF]      = c_reg.refused;
      c_next.refused            = 1'b0;
    end
    if (WR && !ok)
      c_next.refused = 1'b1;
    // busy as its own flop, so the pin never shows decode glitches
    c_next.busy = (c_next.st != C_IDLE);
  end

  // -------------------------------------------------------------
  // state register
  // -------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      c_reg         <= '0;
      c_reg.st      <= C_IDLE;
      c_reg.ret     <= C_IDLE;
      c_reg.ck      <= 1'b1;
      c_reg.dqs_c   <= 1'b1;
      c_reg.cls     <= SW_SHORT;
      c_reg.sp_ctl  <= SP_CTL_RST;
      c_reg.cmd_ref <= {CMD_REF_RST, CMD_REF_RST};
    end
    else
      c_reg <= c_next;
  end

  // outputs straight from the state register
  assign LINK.ck     = c_reg.ck;
  assign LINK.mrw    = c_reg.mrw;
  assign LINK.ma     = c_reg.ma;
  assign LINK.op     = c_reg.op;
  assign LINK.dqs_t  = {2{c_reg.dqs_t}};
  assign LINK.dqs_c  = {2{c_reg.dqs_c}};
  assign LINK.dqs_oe = c_reg.dqs_oe;
  assign RDATA       = c_reg.rdata;
  assign BUSY        = c_reg.busy;
endmodule

// File: verification/fsp_wl_sva.sv
// concurrent checks on the set-point and leveling link
`timescale 1ns/1ps
module fsp_wl_sva
(
  // clock and reset
  input wire logic        CLK,
  input wire logic        NRST,
  // link
  input wire logic        ck,
  input wire logic        mrw,
  input wire logic [5:0]  ma,
  input wire logic [7:0]  op,
  input wire logic [1:0]  dqs_t,
  input wire logic [1:0]  dqs_c,
  input wire logic        dqs_oe,
  input wire logic [15:0] dq_o,
  input wire logic        dq_oe
);
  import fsp_wl_pkg::*;
  logic       sel_reg;    // set last commanded
  logic       ck_reg;
  logic [3:0] still_reg;  // cycles since ck last moved
  logic [7:0] rise_reg;   // ck rises since leveling entry, saturating
  logic [7:0] gap_reg;    // cycles since fast-vref switch command
  // ---------------------------------------------------------------
  // helper logic
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST)
    if (!NRST)
    begin
      sel_reg   <= 1'b0;
      ck_reg    <= 1'b1;
      still_reg <= 4'h0;
      rise_reg  <= 8'h00;
      gap_reg   <= 8'hFF;
    end
    else
    begin
      ck_reg    <= ck;
      still_reg <= (ck != ck_reg) ? 4'h0 : still_reg + 4'h1;
      if ($rose(mrw) && ma == MR_SP_CTL)
        sel_reg <= op[OPSEL_BIT];
      if ($rose(mrw) && ma == MR_LAT_LVL && op[WLEN_BIT])
        rise_reg <= 8'h00;
      else if (ck && !ck_reg && rise_reg != 8'hFF)
        rise_reg <= rise_reg + 8'h01;
      // saturate so a stale switch never looks recent
      if ($rose(mrw) && ma == MR_SP_CTL && op[VREF_CURRENT_MODE_BIT])
        gap_reg <= 8'h00;
      else if (gap_reg != 8'hFF)
        gap_reg <= gap_reg + 8'h01;
    end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_strobe_pair: assert property (dqs_c == ~dqs_t)
    else $error("strobe pair not complementary");
  a_switch_fast: assert property ($rose(mrw) && ma == MR_SP_CTL && op[OPSEL_BIT] != sel_reg
    |-> op[VREF_CURRENT_MODE_BIT]) else $error("set switch without fast vref");
  a_vref_wait: assert property ($rose(mrw) && ma == MR_SP_CTL && !op[VREF_CURRENT_MODE_BIT]
    |-> gap_reg >= FC_SHORT_CYC + CK_PER) else $error("vref normal too early");
  a_ck_alive: assert property (still_reg < CK_PER)
    else $error("link clock stalled");
  a_lvl_enter: assert property ($rose(mrw) && ma == MR_LAT_LVL && op[WLEN_BIT]
    |-> ##[1:20] dq_oe) else $error("leveling entry not taken");
  a_dq_entry: assert property ($rose(dq_oe) |-> dq_o == 16'h0000)
    else $error("data pins not parked on entry");
  a_strobe_en: assert property ($rose(dqs_oe) |-> rise_reg >= WL_DQS_EN_NCK)
    else $error("strobes driven too early");
  a_first_pulse: assert property ($rose(dqs_t[0]) |-> rise_reg >= WL_FIRST_NCK)
    else $error("first strobe too early");
  a_fb_low: assert property ($rose(dqs_t[0]) |-> ##3 dq_o[7:0] == {8{$past(ck, 3)}})
    else $error("low byte feedback wrong");
  a_fb_high: assert property ($rose(dqs_t[1]) |-> ##3 dq_o[15:8] == {8{$past(ck, 3)}})
    else $error("high byte feedback wrong");
  c_switch: cover property ($rose(mrw) && ma == MR_SP_CTL && op[VREF_CURRENT_MODE_BIT]);
  c_level: cover property ($rose(mrw) && ma == MR_LAT_LVL && op[WLEN_BIT]);
  c_pulse: cover property ($rose(dqs_t[0]));
endmodule

// File: verification/testbench.sv
// self-checking bench for the set-point switch and write-leveling link
`timescale 1ns/1ps
module testbench;
  import fsp_wl_pkg::*;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic        busy, act_set, switching, vref_fast, wl_active;
  sw_class_t   sw_class;
  int          n_mismatch = 0;
  int          compares = 0;
  int          ref_q[2];  // model: command reference per set
  int          cur;       // model: active set
  int          sw_cnt = 0;
  int          sw_run = 0;  // cycles the last switch stood busy in the dram
  always #5 clk = ~clk;
  // measure how long the dram holds its switching flag
  always @(posedge clk)
    if (switching === 1'b1)
      sw_cnt <= sw_cnt + 1;
    else if (sw_cnt != 0)
    begin
      sw_run <= sw_cnt;
      sw_cnt <= 0;
    end
  // ---------------------------------------------------------------
  // both ends joined by the link
  // ---------------------------------------------------------------
  fsp_wl_if link ();
  fsp_wl_ctl fsp_wl_ctl_inst (.CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .BUSY(busy), .LINK(link));
  fsp_wl_dram fsp_wl_dram_inst (.CLK(clk), .NRST(nrst), .LINK(link), .ACTIVE_SET(act_set),
    .SWITCHING(switching), .SWITCH_CLASS(sw_class), .VREF_FAST(vref_fast),
    .WL_ACTIVE(wl_active));
  fsp_wl_sva fsp_wl_sva_inst (.CLK(clk), .NRST(nrst), .ck(link.ck), .mrw(link.mrw),
    .ma(link.ma), .op(link.op), .dqs_t(link.dqs_t), .dqs_c(link.dqs_c),
    .dqs_oe(link.dqs_oe), .dq_o(link.dq_o), .dq_oe(link.dq_oe));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic give_verdict();
    if (n_mismatch == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    @(posedge clk);
    #1;
    while (busy !== 1'b0 && n < 4000)
    begin
      @(posedge clk);
      #1 n++;
    end
    check(busy, 0);
  endtask
  task automatic mrw_cmd(input logic [5:0] a, input logic [7:0] v);
    reg_wr(REG_MRW, {18'h0, a, v});
    wait_idle();
  endtask
  task automatic chk_status(input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] d;
    reg_rd(REG_STATUS, d);
    check(d & mask, exp);
  endtask
  // model: range change long, one step short, more steps middle
  function automatic int model_class();
    int d;
    d = (ref_q[0] & 63) - (ref_q[1] & 63);
    if (((ref_q[0] ^ ref_q[1]) & 64) != 0)
      return 2;
    return (d > 1 || d < -1) ? 1 : 0;
  endfunction
  // model: settle cycles of the switch by class
  function automatic int model_fc();
    case (model_class())
      2:       return FC_LONG_CYC;
      1:       return FC_MIDDLE_CYC;
      default: return FC_SHORT_CYC;
    endcase
  endfunction
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial
  begin
    int nv;
    logic [31:0] d;
    int fb;
    void'($urandom(30717));
    ref_q[0] = 'h4D;
    ref_q[1] = 'h4D;
    cur = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    chk_status(32'h0000_01C7, 0);
    check(act_set, 0);
    reg_wr(8'hF0, $urandom);
    reg_rd(8'h04, d);
    check(d, 0);
    for (int k = 0; k < 6; k++)
    begin
      nv = (k % 3 == 0) ? 1 : 2 + $urandom % 8;
      nv = ((ref_q[cur] & 63) < 32) ? (ref_q[cur] & 63) + nv : (ref_q[cur] & 63) - nv;
      ref_q[1 - cur] = nv + ((ref_q[cur] & 64) ^ ((k % 3 == 2) ? 64 : 0));
      mrw_cmd(MR_SP_CTL, 8'(cur * 128 + (1 - cur) * 64));
      mrw_cmd(MR_CMD_REF, 8'(ref_q[1 - cur]));
      reg_wr(REG_FSP, 32'(1 - cur));
      // second request while busy must be refused
      if (k == 0)
        reg_wr(REG_FSP, 32'(cur));
      cur = 1 - cur;
      wait_idle();
      check(act_set, cur);
      check(32'(sw_class), model_class());
      check(sw_run, model_fc());
      check(vref_fast, 0);
      chk_status(32'h0000_01C7, cur * 2 + model_class() * 64 + (k == 0) * 256);
    end
    // a raw set change must be turned away; only the switch register may do it
    reg_wr(REG_MRW, {18'h0, MR_SP_CTL, 8'((1 - cur) * 128)});
    chk_status(32'h0000_0103, cur * 2 + 256);
    check(act_set, cur);
    mrw_cmd(MR_LAT_LVL, 8'h80);
    check(wl_active, 1);
    d = 0;
    for (int i = 0; i < 300 && d[ST_RDY] !== 1'b1; i++)
      reg_rd(REG_STATUS, d);
    check(d[ST_RDY], 1);
    reg_wr(REG_FSP, 32'(1 - cur));
    for (int j = 1; j < 12; j++)
      if (j != 6)
      begin
        reg_wr(REG_PULSE, 32'(j * 256 + $urandom % 4));
        wait_idle();
        // the strobe rises one clock after its phase count, so that is where ck is seen
        fb = (((j + 1) % CK_PER) < CK_HALF) ? 3 : 0;
        check(link.dq_o, {{8{fb[1]}}, {8{fb[0]}}});
        chk_status(32'h0000_0134, fb * 16 + 4 + (j == 1) * 256);
      end
    mrw_cmd(MR_LAT_LVL, 8'h00);
    check(wl_active, 0);
    chk_status(32'h0000_0106, cur * 2);
    give_verdict();
  end
  // watchdog well past the expected run
  initial
  begin
    #200_000;
    n_mismatch++;
    give_verdict();
  end
endmodule
